// ===== rtl/etx_mac_port.sv
// Transmit client port, MAC end: intake, frame engine and status.
`timescale 1ns/10ps
`include "etx_map.svh"

module etx_mac_port
	import etx_pkg::*;
#(
	parameter int HANDSHAKE_DELAY_CYCLES = `ETX_DEF_READY_LATENCY,
	parameter int DEPTH                  = `ETX_DEF_DEPTH
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	etx_if.dev               link,
	output logic [63:0]      lineWord,
	output logic [3:0]       lineBytes,
	output logic             lineFirst,
	output logic             lineLast,
	output logic [15:0]      statFrames,
	output logic [15:0]      statErrors
);
	localparam int L  = HANDSHAKE_DELAY_CYCLES;
	localparam int AW = $clog2(DEPTH);

	function automatic logic [31:0] crcWord(input logic [31:0] c,
		input logic [63:0] w, input logic [3:0] n);
		logic [31:0] r;
		r = c;
		for (int b = 0; b < 8; b++) begin
			for (int k = 0; k < 8; k++) begin
				if (4'(b) < n)
					r = (r[0] ^ w[56-8*b+k]) ?
						((r >> 1) ^ `ETX_CRC_POLY) : (r >> 1);
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Lane settle
	// ----------------------------------------------------------------
	logic [15:0] settleCount;
	wire         settled = (settleCount == 16'(`ETX_SETTLE_CYCLES));

	always_ff @(posedge core_clk) begin
		if (rst) begin
			settleCount        <= 16'h0000;
			link.txLanesStable <= 1'b0;
		end else begin
			if (!settled)
				settleCount <= settleCount + 16'h0001;
			link.txLanesStable <= settled;
		end
	end

	// ----------------------------------------------------------------
	// Ready schedule
	// ----------------------------------------------------------------
	wire [L:0]     sched;
	logic [AW+1:0] pend;

	for (genvar k = 0; k <= L; k++) begin : g_sched
		if (k == 0) begin : g_tap
			assign sched[k] = link.txAccept;
		end else begin : g_stage
			logic q;
			always_ff @(posedge core_clk) begin
				if (rst)
					q <= 1'b0;
				else
					q <= sched[k-1];
			end
			assign sched[k] = q;
		end
	end

	always_comb begin
		pend = '0;
		for (int k = 0; k < L; k++)
			pend = pend + (AW+2)'(sched[k]);
	end

	// ----------------------------------------------------------------
	// Intake
	// ----------------------------------------------------------------
	etx_entry_t    mem [DEPTH];
	etx_entry_t    inEntry;
	etx_entry_t    head;
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0]   fill;
	logic          inFrame;
	logic          pop;

	wire readyCycle = sched[L];
	wire take       = readyCycle & link.txWordValid;
	wire startOk    = link.txFrameFirst & ~link.txFrameLast;
	wire midOk      = inFrame & ~link.txFrameFirst;
	wire push       = take & (startOk | midOk);
	wire next_inFrame = take ? (startOk | (midOk & ~link.txFrameLast))
		: inFrame;
	wire [2:0] inEmpty = link.txFrameLast ? link.txUnusedByteCount
		: 3'h0;

	assign inEntry = '{word:  link.txWordIn,
		first: link.txFrameFirst,
		last:  link.txFrameLast,
		empty: inEmpty,
		bad:   link.txFrameBad & link.txFrameLast};
	assign head = mem[rdPtr];

	wire           headValid = (fill != '0);
	wire [AW:0]    next_fill = fill + (AW+1)'(push) - (AW+1)'(pop);
	// Credits cover words already promised by earlier ready cycles, so
	// the store can never overflow whatever the latency.
	wire [AW+1:0]  credit    = (AW+2)'(fill) + pend + (AW+2)'(2);
	wire           next_accept = link.txLanesStable &
		(credit <= (AW+2)'(DEPTH));

	always_ff @(posedge core_clk) begin
		if (push)
			mem[wrPtr] <= inEntry;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wrPtr         <= '0;
			rdPtr         <= '0;
			fill          <= '0;
			inFrame       <= 1'b0;
			link.txAccept <= 1'b0;
		end else begin
			wrPtr         <= wrPtr + AW'(push);
			rdPtr         <= rdPtr + AW'(pop);
			fill          <= next_fill;
			inFrame       <= next_inFrame;
			link.txAccept <= next_accept;
		end
	end

	// ----------------------------------------------------------------
	// Frame engine
	// ----------------------------------------------------------------
	etx_state_t  state;
	etx_state_t  next_state;
	logic [15:0] byteCount;
	logic [15:0] dataBytes;
	logic [31:0] crc;
	logic [1:0]  wordIdx;
	logic [63:0] hdr0;
	logic [63:0] hdr1;
	logic [63:0] hdr2;
	logic        badFrame;
	logic [1:0]  gapCount;
	logic [63:0] next_lineWord;
	logic [3:0]  next_lineBytes;
	logic        next_lineFirst;
	logic        next_lineLast;
	logic        next_report;

	wire [3:0]  headBytes = head.last ? (4'h8 - {1'b0, head.empty})
		: 4'h8;
	wire [15:0] dataEnd = byteCount + 16'(headBytes);
	wire [15:0] padLeft = 16'(`ETX_MIN_PADDED_BYTES) - byteCount;
	wire [3:0]  padN    = (padLeft >= 16'h0008) ? 4'h8 : padLeft[3:0];
	wire        inData  = (state == ST_DATA);
	wire [31:0] crcNext = crcWord(crc, inData ? head.word : 64'h0,
		inData ? headBytes : padN);
	wire [31:0] fcsVal  = badFrame ? crc : ~crc;
	wire [31:0] fcs     = {fcsVal[7:0], fcsVal[15:8], fcsVal[23:16],
		fcsVal[31:24]};

	always_comb begin
		next_state     = state;
		pop            = 1'b0;
		next_lineWord  = 64'h0;
		next_lineBytes = 4'h0;
		next_lineFirst = 1'b0;
		next_lineLast  = 1'b0;
		next_report    = 1'b0;
		case (state)
			ST_IDLE: begin
				if (headValid && head.first) begin
					next_lineWord  = `ETX_PREAMBLE;
					next_lineBytes = 4'h8;
					next_lineFirst = 1'b1;
					next_state     = ST_DATA;
				end else if (headValid) begin
					pop = 1'b1;
				end
			end
			ST_DATA: begin
				if (headValid) begin
					pop            = 1'b1;
					next_lineWord  = head.word;
					next_lineBytes = headBytes;
					if (head.last)
						next_state = (dataEnd <
							16'(`ETX_MIN_PADDED_BYTES)) ? ST_PAD : ST_FCS;
				end
			end
			ST_PAD: begin
				next_lineBytes = padN;
				if (padLeft <= 16'h0008)
					next_state = ST_FCS;
			end
			ST_FCS: begin
				next_lineWord  = {fcs, 32'h0};
				next_lineBytes = 4'(`ETX_FCS_BYTES);
				next_lineLast  = 1'b1;
				next_report    = 1'b1;
				next_state     = ST_GAP;
			end
			ST_GAP: begin
				if (gapCount == 2'h1)
					next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state     <= ST_IDLE;
			byteCount <= 16'h0000;
			dataBytes <= 16'h0000;
			crc       <= `ETX_CRC_INIT;
			wordIdx   <= 2'h0;
			hdr0      <= 64'h0;
			hdr1      <= 64'h0;
			hdr2      <= 64'h0;
			badFrame  <= 1'b0;
			gapCount  <= 2'h0;
		end else begin
			state <= next_state;
			if (state == ST_IDLE) begin
				byteCount <= 16'h0000;
				crc       <= `ETX_CRC_INIT;
				wordIdx   <= 2'h0;
				hdr1      <= 64'h0;
				hdr2      <= 64'h0;
			end else if (inData && headValid) begin
				byteCount <= dataEnd;
				dataBytes <= dataEnd;
				crc       <= crcNext;
				wordIdx   <= (wordIdx == 2'h3) ? wordIdx : wordIdx + 2'h1;
				if (wordIdx == 2'h0)
					hdr0 <= head.word;
				if (wordIdx == 2'h1)
					hdr1 <= head.word;
				if (wordIdx == 2'h2)
					hdr2 <= head.word;
				if (head.last)
					badFrame <= head.bad;
			end else if (state == ST_PAD) begin
				byteCount <= byteCount + 16'(padN);
				crc       <= crcNext;
			end
			gapCount <= (state == ST_FCS) ? 2'(`ETX_GAP_WORDS)
				: gapCount - 2'(state == ST_GAP);
		end
	end

	// ----------------------------------------------------------------
	// Status report and statistics
	// ----------------------------------------------------------------
	wire [15:0] outerType = hdr1[31:16];
	wire [15:0] opcode    = hdr1[15:0];
	wire [15:0] innerType = hdr2[63:48];
	wire        bcast     = (hdr0[63:16] == 48'hffffffffffff);
	wire        vlan      = (outerType == `ETX_TYPE_VLAN) |
		(outerType == `ETX_TYPE_QINQ);
	wire        stacked   = (outerType == `ETX_TYPE_QINQ) |
		((outerType == `ETX_TYPE_VLAN) & (innerType == `ETX_TYPE_VLAN));
	wire        ctrl      = (outerType == `ETX_TYPE_CTRL);
	wire [15:0] hdrLen    = stacked ? 16'(`ETX_HDR_STACKED)
		: vlan ? 16'(`ETX_HDR_VLAN) : 16'(`ETX_HDR_PLAIN);
	wire [15:0] payload   = (dataBytes > hdrLen) ? dataBytes - hdrLen
		: 16'h0000;
	wire [15:0] total     = byteCount + 16'(`ETX_FCS_BYTES);
	wire [15:0] lenLimit  = 16'(`ETX_LONGEST_FRAME_BYTES) + (vlan ?
		16'h0004 : 16'h0000);
	wire        oversize  = (total > lenLimit);
	wire [39:0] report    = {ctrl & (opcode == `ETX_OP_PFC),
		~hdr0[56], hdr0[56] & ~bcast, bcast,
		ctrl & (opcode == `ETX_OP_PAUSE), ctrl, vlan, stacked,
		total, payload};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			lineWord            <= 64'h0;
			lineBytes           <= 4'h0;
			lineFirst           <= 1'b0;
			lineLast            <= 1'b0;
			link.txReportStrobe <= 1'b0;
			link.txReportWord   <= 40'h0;
			statFrames          <= 16'h0000;
			statErrors          <= 16'h0000;
		end else begin
			lineWord            <= next_lineWord;
			lineBytes           <= next_lineBytes;
			lineFirst           <= next_lineFirst;
			lineLast            <= next_lineLast;
			link.txReportStrobe <= next_report;
			if (next_report) begin
				link.txReportWord <= report;
				statFrames        <= statFrames + 16'h0001;
				statErrors        <= statErrors +
					16'(oversize & ~badFrame);
			end
		end
	end
endmodule

// ===== pkg/etx_map.svh
// Constants shared by both ends of the transmit client port.
`ifndef ETX_MAP_SVH
`define ETX_MAP_SVH

// ----------------------------------------------------------------
// Link shape
// ----------------------------------------------------------------
`define ETX_WORD_BITS          64
`define ETX_EMPTY_BITS         3
`define ETX_REPORT_BITS        40
`define ETX_DEF_READY_LATENCY  2
`define ETX_DEF_DEPTH          32

// ----------------------------------------------------------------
// Frame construction
// ----------------------------------------------------------------
`define ETX_MIN_FRAME_BYTES    9
`define ETX_MIN_PADDED_BYTES   60
`define ETX_LONGEST_FRAME_BYTES 1518
`define ETX_FCS_BYTES          4
`define ETX_GAP_WORDS          2
`define ETX_PREAMBLE           64'h55555555555555d5
`define ETX_CRC_INIT           32'hffffffff
`define ETX_CRC_POLY           32'hedb88320
`define ETX_TYPE_VLAN          16'h8100
`define ETX_TYPE_QINQ          16'h88a8
`define ETX_TYPE_CTRL          16'h8808
`define ETX_OP_PAUSE           16'h0001
`define ETX_OP_PFC             16'h0101
`define ETX_HDR_PLAIN          14
`define ETX_HDR_VLAN           18
`define ETX_HDR_STACKED        22

// ----------------------------------------------------------------
// Status word layout
// ----------------------------------------------------------------
`define ETX_ST_PFC             39
`define ETX_ST_UNICAST         38
`define ETX_ST_MULTICAST       37
`define ETX_ST_BROADCAST       36
`define ETX_ST_PAUSE           35
`define ETX_ST_CONTROL         34
`define ETX_ST_VLAN            33
`define ETX_ST_STACKED         32
`define ETX_ST_TOTAL_MSB       31
`define ETX_ST_TOTAL_LSB       16
`define ETX_ST_PAYLOAD_MSB     15
`define ETX_ST_PAYLOAD_LSB     0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ETX_CLK_PERIOD_NS      10
`define ETX_SETTLE_NS          1000
`define ETX_SETTLE_CYCLES      ((`ETX_SETTLE_NS + `ETX_CLK_PERIOD_NS - 1) / `ETX_CLK_PERIOD_NS)

`endif

// ===== pkg/etx_pkg.sv
// Types shared by both ends of the transmit client port.
package etx_pkg;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_DATA = 5'b00010,
		ST_PAD  = 5'b00100,
		ST_FCS  = 5'b01000,
		ST_GAP  = 5'b10000
	} etx_state_t;

	typedef struct packed {
		logic [63:0] word;
		logic        first;
		logic        last;
		logic [2:0]  empty;
		logic        bad;
	} etx_entry_t;

endpackage

// ===== pkg/etx_if.sv
// Transmit client link between user logic and the MAC end.
`timescale 1ns/10ps

interface etx_if;
	logic [63:0] txWordIn;
	logic        txWordValid;
	logic        txFrameFirst;
	logic        txFrameLast;
	logic [2:0]  txUnusedByteCount;
	logic        txFrameBad;
	logic        txAccept;
	logic        txReportStrobe;
	logic [39:0] txReportWord;
	logic        txLanesStable;

	modport dev (
		input  txWordIn,
		input  txWordValid,
		input  txFrameFirst,
		input  txFrameLast,
		input  txUnusedByteCount,
		input  txFrameBad,
		output txAccept,
		output txReportStrobe,
		output txReportWord,
		output txLanesStable
	);

	modport client (
		output txWordIn,
		output txWordValid,
		output txFrameFirst,
		output txFrameLast,
		output txUnusedByteCount,
		output txFrameBad,
		input  txAccept,
		input  txReportStrobe,
		input  txReportWord,
		input  txLanesStable
	);
endinterface

// ===== rtl/etx_client.sv
// Transmit client port, user end: paces user words onto the link.
`timescale 1ns/10ps
`include "etx_map.svh"

module etx_client
	import etx_pkg::*;
#(
	parameter int HANDSHAKE_DELAY_CYCLES = `ETX_DEF_READY_LATENCY
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	etx_if.client            link,
	input  wire logic [63:0] usrWord,
	input  wire logic        usrValid,
	input  wire logic        usrFirst,
	input  wire logic        usrLast,
	input  wire logic [2:0]  usrEmpty,
	input  wire logic        usrBad,
	output logic             usrReady,
	output logic             usrDropped
);
	// The link outputs are registered, so the ready cycle must be known
	// two cycles ahead; this end therefore needs a latency of two or more.
	localparam int A = HANDSHAKE_DELAY_CYCLES - 2;

	// ----------------------------------------------------------------
	// Ready cycle lookahead
	// ----------------------------------------------------------------
	wire [A:0] ahead;

	for (genvar k = 0; k <= A; k++) begin : g_ahead
		if (k == 0) begin : g_tap
			assign ahead[k] = link.txAccept;
		end else begin : g_stage
			logic q;
			always_ff @(posedge core_clk) begin
				if (rst)
					q <= 1'b0;
				else
					q <= ahead[k-1];
			end
			assign ahead[k] = q;
		end
	end

	wire readyAhead = ahead[A] & link.txLanesStable;
	wire send       = usrReady & usrValid;
	wire tooShort   = usrFirst & usrLast;

	// ----------------------------------------------------------------
	// Link drive
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			usrReady               <= 1'b0;
			usrDropped             <= 1'b0;
			link.txWordValid       <= 1'b0;
			link.txWordIn          <= 64'h0;
			link.txFrameFirst      <= 1'b0;
			link.txFrameLast       <= 1'b0;
			link.txUnusedByteCount <= 3'h0;
			link.txFrameBad        <= 1'b0;
		end else begin
			usrReady               <= readyAhead;
			usrDropped             <= send & tooShort;
			link.txWordValid       <= send & ~tooShort;
			link.txWordIn          <= usrWord;
			link.txFrameFirst      <= usrFirst;
			link.txFrameLast       <= usrLast;
			link.txUnusedByteCount <= usrEmpty;
			link.txFrameBad        <= usrBad;
		end
	end
endmodule

// ===== verif/etx_link_chk.sv
// Checker of the transmit client link between the two ends.
`timescale 1ns/10ps

module etx_link_chk #(
	parameter int HANDSHAKE_DELAY_CYCLES = 2
) (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic [63:0] txWordIn,
	input wire logic        txWordValid,
	input wire logic        txFrameFirst,
	input wire logic        txFrameLast,
	input wire logic [2:0]  txUnusedByteCount,
	input wire logic        txFrameBad,
	input wire logic        txAccept,
	input wire logic        txReportStrobe,
	input wire logic [39:0] txReportWord,
	input wire logic        txLanesStable
);
	// ------------------------------------------------------------
	// Frame boundaries
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence seqFrameOpen;
		txWordValid && txFrameFirst && !txFrameLast;
	endsequence

	sequence seqFrameClose;
		txWordValid && txFrameLast && !txFrameFirst;
	endsequence

	// ------------------------------------------------------------
	// Link rules
	// ------------------------------------------------------------
	chk_ready_cycle_only: assert property (
		txWordValid |-> $past(txAccept, HANDSHAKE_DELAY_CYCLES))
		else $error("word sent outside a ready cycle");
	chk_valid_run: assert property (
		seqFrameOpen |=> txWordValid)
		else $error("valid dropped inside a frame");
	chk_valid_hold: assert property (
		txWordValid && !txFrameLast |=> txWordValid)
		else $error("valid gap before end of frame");
	chk_no_single: assert property (
		txWordValid |-> !(txFrameFirst && txFrameLast))
		else $error("single word frame on the link");
	chk_strobe_pulse: assert property (
		txReportStrobe |=> !txReportStrobe)
		else $error("report strobe longer than one cycle");
	chk_report_hold: assert property (
		!txReportStrobe |-> $stable(txReportWord))
		else $error("report word changed without strobe");
	chk_accept_lanes: assert property (
		txAccept |-> txLanesStable)
		else $error("ready offered before lanes stable");
	chk_settle_wait: assert property (
		$fell(rst) |-> !txLanesStable [*8])
		else $error("lanes stable too soon after reset");
	chk_lanes_hold: assert property (
		$rose(txLanesStable) |=> txLanesStable [*8])
		else $error("lanes stable did not hold");
	chk_report_after: assert property (
		seqFrameClose |-> ##[2:200] txReportStrobe)
		else $error("no report after a frame");
	chk_report_size: assert property (
		txReportStrobe |-> txReportWord[31:16] >= 16'h0040 &&
		txReportWord[15:0] < txReportWord[31:16])
		else $error("report lengths out of range");
endmodule

// ===== verif/testbench.sv
// Self-checking bench joining the user end and the MAC end.
`timescale 1ns/10ps
`include "etx_map.svh"

module testbench;
	localparam int LAT = 2;
	logic        core_clk;
	logic        rst;
	logic [63:0] usrWord;
	logic        usrValid;
	logic        usrFirst;
	logic        usrLast;
	logic [2:0]  usrEmpty;
	logic        usrBad;
	logic        usrReady;
	logic        usrDropped;
	logic [63:0] lineWord;
	logic [3:0]  lineBytes;
	logic        lineFirst;
	logic        lineLast;
	logic [15:0] statFrames;
	logic [15:0] statErrors;
	logic [7:0]  lineQ[$];
	logic [63:0] preSeen;
	logic [31:0] fcsSeen;
	logic [39:0] rep;
	int          repCnt = 0;
	int          dropCnt = 0;
	int          cycles = 0;
	int          error_cnt = 0;
	int          cmp_count = 0;

	etx_if link();

	etx_client #(.HANDSHAKE_DELAY_CYCLES(LAT)) etx_client_inst (
		.core_clk(core_clk), .rst(rst), .link(link), .usrWord(usrWord),
		.usrValid(usrValid), .usrFirst(usrFirst), .usrLast(usrLast),
		.usrEmpty(usrEmpty), .usrBad(usrBad), .usrReady(usrReady),
		.usrDropped(usrDropped));

	etx_mac_port #(.HANDSHAKE_DELAY_CYCLES(LAT)) etx_mac_port_inst (
		.core_clk(core_clk), .rst(rst), .link(link), .lineWord(lineWord),
		.lineBytes(lineBytes), .lineFirst(lineFirst), .lineLast(lineLast),
		.statFrames(statFrames), .statErrors(statErrors));

	etx_link_chk #(.HANDSHAKE_DELAY_CYCLES(LAT)) etx_link_chk_inst (
		.core_clk(core_clk), .rst(rst), .txWordIn(link.txWordIn),
		.txWordValid(link.txWordValid), .txFrameFirst(link.txFrameFirst),
		.txFrameLast(link.txFrameLast),
		.txUnusedByteCount(link.txUnusedByteCount),
		.txFrameBad(link.txFrameBad), .txAccept(link.txAccept),
		.txReportStrobe(link.txReportStrobe),
		.txReportWord(link.txReportWord),
		.txLanesStable(link.txLanesStable));

	// ------------------------------------------------------------
	// Clock, line monitor and hang guard
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (usrDropped === 1'b1)
			dropCnt++;
		if (link.txReportStrobe === 1'b1) begin
			rep = link.txReportWord;
			repCnt++;
		end
		if (lineFirst === 1'b1) begin
			lineQ.delete();
			preSeen = lineWord;
		end else if (lineLast === 1'b1) begin
			fcsSeen = lineWord[63:32];
		end else begin
			for (int i = 0; i < lineBytes; i++)
				lineQ.push_back(lineWord[63 - 8 * i -: 8]);
		end
		if (cycles == 20000) begin
			error_cnt++;
			test_done();
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] crc_upd(logic [31:0] c, logic [7:0] b);
		c = c ^ {24'h0, b};
		for (int i = 0; i < 8; i++)
			c = c[0] ? (c >> 1) ^ `ETX_CRC_POLY : c >> 1;
		return c;
	endfunction

	// Frame byte k is base plus k; empty is garbage on inner words so
	// that a design reading it too early shows up in the byte count.
	task automatic send_frame(input int n, input logic [7:0] base,
			input int badAt);
		int w;
		int nw;
		nw = (n + 7) / 8;
		w = 0;
		while (w < nw) begin
			@(negedge core_clk);
			usrValid = 1'b1;
			usrFirst = (w == 0);
			usrLast = (w == nw - 1);
			usrEmpty = usrLast ? 3'(8 * nw - n) : 3'h5;
			usrBad = usrLast ? (badAt == 1) : (badAt == 2);
			for (int k = 0; k < 8; k++)
				usrWord[63 - 8 * k -: 8] = base + 8'(8 * w + k);
			if (usrReady)
				w++;
		end
		@(negedge core_clk);
		usrValid = 1'b0;
	endtask

	task automatic run_frame(input string name, input int n,
			input logic [7:0] base, input int badAt);
		int start;
		int total;
		int t;
		logic [31:0] crc;
		logic [7:0] b;
		start = repCnt;
		send_frame(n, base, badAt);
		t = 0;
		while (repCnt == start && t < 300) begin
			@(posedge core_clk);
			t++;
		end
		check(64'(repCnt - start), 64'h1);
		total = (n < `ETX_MIN_PADDED_BYTES) ? `ETX_MIN_PADDED_BYTES : n;
		crc = `ETX_CRC_INIT;
		check(64'(lineQ.size()), 64'(total));
		for (int k = 0; k < total; k++) begin
			b = (k < n) ? base + 8'(k) : 8'h00;
			check(64'(lineQ[k]), 64'(b));
			crc = crc_upd(crc, b);
		end
		if (badAt != 1)
			crc = ~crc;
		crc = {crc[7:0], crc[15:8], crc[23:16], crc[31:24]};
		check(64'(fcsSeen), 64'(crc));
		check(preSeen, `ETX_PREAMBLE);
		check(64'(rep[31:16]), 64'(total + 4));
		check(64'(rep[15:0]), 64'((n > 14) ? n - 14 : 0));
		check(64'(rep[39:32]), 64'({1'b0, ~base[0], base[0], 5'h0}));
		check(64'(statErrors), 64'h0);
		$display("test %s done", name);
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		int r0;
		int d0;
		rst = 1'b1;
		usrWord = 64'h0;
		usrValid = 1'b0;
		usrFirst = 1'b0;
		usrLast = 1'b0;
		usrEmpty = 3'h0;
		usrBad = 1'b0;
		repeat (20) @(negedge core_clk);
		rst = 1'b0;
		run_frame("shortest", 9, 8'h10, 0);
		run_frame("full_words", 64, 8'h21, 0);
		run_frame("bad_last", 61, 8'h40, 1);
		run_frame("bad_inner", 100, 8'h02, 2);
		run_frame("oversize_bad", 1515, 8'h60, 1);
		r0 = repCnt;
		d0 = dropCnt;
		send_frame(8, 8'h30, 0);
		repeat (40) @(posedge core_clk);
		check(64'(dropCnt - d0), 64'h1);
		check(64'(repCnt - r0), 64'h0);
		$display("test single_word done");
		run_frame("after_drop", 20, 8'h50, 0);
		check(64'(statFrames), 64'h6);
		test_done();
	end
endmodule
